/* File: hw/swf_wake_filter.sv */
// Purpose: selective wake filter of a CAN transceiver, pattern and frame wake
// Assumes: rst is the supply power-on reset; rxPin is asynchronous
// Notes:   registers reached over classic Wishbone, one ack per access
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - selective wake works in normal, stop and sleep device modes alike.
// - wake pattern is two long dominant phases split by recessive.
// - decoder defaults to 500 kBaud; 125k, 250k and custom up to 1M.
// - up to four data frames after bias switch-on may be ignored.
// - with selective wake enabled, a valid wake frame wakes the transceiver.
// - identifier matches configured one on every masked bit, 11 or 29 bits.
// - received length code must equal configured length code.
// - nonzero length needs one received data bit set under the mask.
// - wake frame must be error free; ack and end-of-frame errors ignored.
// - stuff, CRC or form error increments the error counter.
// - frame correct through CRC decrements a nonzero counter.
// - increment at 31 disables, wakes, sets fault flag, shows 32; done only in frame detection, elsewhere it just shows 32.
// - after each count change wait 6 to 10 recessive bits before SOF.
// - counter runs only in normal, receive-only or wake-frame detection.
// - counter cleared entering frame detection and on silence exit.
// - counter cleared when the transceiver is rearmed.
// - counter cleared in off modes and plain wake-capable mode.
// - counter held at zero while FD tolerance and count disable set.
// - counter frozen while the transceiver stays woken.
// - counter value readable in a status field.
// - power-on indication bit latched in status after supply power-on.
// - supply power-on restores reset values; selective wake unconfigured.
// - interrupt pulses low when fault flag sets, unless masked.
module swf_wake_filter #(
  parameter int unsigned SILENCE_CYC   = swf_pkg::SILENCE_CYC_DEF,
  parameter int unsigned IGNORE_FRAMES = swf_pkg::IGNORE_FRAMES_DEF
) (
  // clock, reset, enable
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           ce,
  // register bus
  input  swf_pkg::swf_wb_req_t wbReq,
  output swf_pkg::swf_wb_rsp_t wbRsp,
  // bus and device side
  input  wire logic           rxPin,
  input  wire logic           biasOn,
  input  wire logic           lowPower,
  output logic                wakeOut,
  output logic                interruptOutN
);
  import swf_pkg::*;

  localparam logic [SIL_W-1:0] SIL_LAST = SIL_W'(SILENCE_CYC - 1);
  localparam logic [15:0]      PAT_LAST = 16'(PAT_MIN_CYC - 1);

  swf_state_t q;
  swf_state_t n;

  function automatic logic [14:0] crcStep(input logic [14:0] c, input logic b);
    logic [14:0] s;
    s = {c[13:0], 1'b0};
    if (b ^ c[14]) begin
      s = s ^ CRC_POLY;
    end
    return s;
  endfunction : crcStep

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : merge

  // ==========================================================================
  // next state
  logic [7:0]  bitLen;
  logic [7:0]  samplePt;
  logic        resync;
  logic        samp;
  logic        bitIn;
  logic        stuffed;
  logic        errEv;
  logic        okEv;
  logic        wupEv;
  logic        silExp;
  logic        frameOk;
  logic        ovfEv;
  logic        faultEv;
  logic        clrCnt;
  logic        cntOn;
  logic        rearmEv;
  logic        modeSwk;
  logic        wbHit;
  logic        wbWr;
  logic [31:0] wv;
  logic [3:0]  nb;
  logic [63:0] aligned;
  logic [28:0] idCmp;
  logic [3:0]  dlcNew;

  always_comb begin : comb
    n       = q;
    errEv   = 1'b0;
    okEv    = 1'b0;
    wupEv   = 1'b0;
    frameOk = 1'b0;
    ovfEv   = 1'b0;
    faultEv = 1'b0;
    clrCnt  = 1'b0;
    rearmEv = 1'b0;
    wv      = '0;
    dlcNew  = '0;

    // pin synchroniser; rx1 feeds rx2 only
    n.rx1      = rxPin;
    n.rx2      = q.rx1;
    n.rxPrev   = q.rx2;
    n.biasPrev = biasOn;

    // ========================================================================
    // register bus
    wbHit   = wbReq.cyc & wbReq.stb;
    n.wbAck = wbHit & ~q.wbAck;
    n.wbDat = '0;
    if (wbHit && !q.wbAck && !wbReq.we) begin
      case (wbReq.adr)
        REG_CTRL: begin
          n.wbDat[CTRL_MODE_LSB +: 3] = q.canMode;
          n.wbDat[CTRL_IDE]           = q.ideExt;
          n.wbDat[CTRL_FD_TOL]        = q.fdTolEn;
          n.wbDat[CTRL_ERR_DIS]       = q.errCntDis;
          n.wbDat[CTRL_CFG_VAL]       = q.cfgValid;
          n.wbDat[CTRL_BAUD_LSB +: 2] = q.baudSel;
          n.wbDat[CTRL_INT_MASK]      = q.busIntMask;
        end
        REG_ID:       n.wbDat = {3'h0, q.cfgId};
        REG_ID_MASK:  n.wbDat = {3'h0, q.idMask};
        REG_DLC:      n.wbDat = {28'h0, q.cfgDlc};
        REG_DMASK_HI: n.wbDat = q.dataMask[63:32];
        REG_DMASK_LO: n.wbDat = q.dataMask[31:0];
        REG_BAUD_DIV: n.wbDat = {24'h0, q.baudDiv};
        REG_STATUS: begin
          n.wbDat[5:0]         = q.error_count_field;
          n.wbDat[STAT_FAULT]   = q.protoFault;
          n.wbDat[STAT_PATTERN] = q.patFlag;
          n.wbDat[STAT_FRAME]   = q.frameFlag;
          n.wbDat[STAT_POR]     = q.porFlag;
          n.wbDat[STAT_WOKEN]   = q.swkState == S_WOKEN;
        end
        default: n.wbDat = '0;
      endcase
    end
    // a write lands on the edge where the master sees ack
    wbWr = wbHit & q.wbAck & wbReq.we;
    if (wbWr) begin
      case (wbReq.adr)
        REG_CTRL: begin
          wv = merge({16'h0, 6'h0, q.busIntMask, q.baudSel, q.cfgValid, q.errCntDis,
                      q.fdTolEn, q.ideExt, q.canMode}, wbReq.dat, wbReq.sel);
          // mode bits locked outside normal device mode
          if (!lowPower) begin
            n.canMode = wv[CTRL_MODE_LSB +: 3];
          end
          n.ideExt     = wv[CTRL_IDE];
          n.fdTolEn    = wv[CTRL_FD_TOL];
          n.errCntDis  = wv[CTRL_ERR_DIS];
          n.cfgValid   = wv[CTRL_CFG_VAL];
          n.baudSel    = wv[CTRL_BAUD_LSB +: 2];
          n.busIntMask = wv[CTRL_INT_MASK];
          rearmEv      = wbReq.sel[2] & wbReq.dat[CTRL_REARM];
        end
        REG_ID: begin
          wv         = merge({3'h0, q.cfgId}, wbReq.dat, wbReq.sel);
          n.cfgId    = wv[28:0];
          n.cfgValid = 1'b0;
        end
        REG_ID_MASK: begin
          wv         = merge({3'h0, q.idMask}, wbReq.dat, wbReq.sel);
          n.idMask   = wv[28:0];
          n.cfgValid = 1'b0;
        end
        REG_DLC: begin
          wv         = merge({28'h0, q.cfgDlc}, wbReq.dat, wbReq.sel);
          n.cfgDlc   = wv[3:0];
          n.cfgValid = 1'b0;
        end
        REG_DMASK_HI: begin
          n.dataMask[63:32] = merge(q.dataMask[63:32], wbReq.dat, wbReq.sel);
          n.cfgValid        = 1'b0;
        end
        REG_DMASK_LO: begin
          n.dataMask[31:0] = merge(q.dataMask[31:0], wbReq.dat, wbReq.sel);
          n.cfgValid       = 1'b0;
        end
        REG_BAUD_DIV: begin
          wv        = merge({24'h0, q.baudDiv}, wbReq.dat, wbReq.sel);
          n.baudDiv = wv[7:0];
        end
        REG_STATUS: begin
          // write one to clear; hardware sets below take priority
          if (wbReq.sel[1] && wbReq.dat[STAT_FAULT]) begin
            n.protoFault = 1'b0;
          end
          if (wbReq.sel[1] && wbReq.dat[STAT_POR]) begin
            n.porFlag = 1'b0;
          end
        end
        default: n.porFlag = q.porFlag;
      endcase
    end

    // ========================================================================
    // bit timing
    case (q.baudSel)
      BAUD_500K: bitLen = BIT_CYC_500K;
      BAUD_125K: bitLen = BIT_CYC_125K;
      BAUD_250K: bitLen = BIT_CYC_250K;
      default:   bitLen = q.baudDiv;
    endcase
    samplePt = bitLen - (bitLen >> 2);
    resync   = q.rxPrev & ~q.rx2;
    if (resync) begin
      n.bitCnt = '0;
    end else if (q.bitCnt >= bitLen - 8'h01) begin
      n.bitCnt = '0;
    end else begin
      n.bitCnt = q.bitCnt + 8'h01;
    end
    samp  = ~resync & (q.bitCnt == samplePt);
    bitIn = q.rx2;

    // ========================================================================
    // frame decoder
    stuffed = (q.decState >= D_ID) && (q.decState <= D_CRC);
    nb      = (q.rxDlc > 4'h8) ? 4'h8 : q.rxDlc;
    if (samp) begin
      if ((stuffed || q.decState == D_DEL) && q.sameCnt == STUFF_RUN) begin
        // stuff bit position
        if (bitIn == q.lastBit) begin
          errEv = 1'b1;
        end else begin
          n.lastBit = bitIn;
          n.sameCnt = 3'h1;
        end
      end else begin
        if (stuffed) begin
          n.sameCnt = (bitIn == q.lastBit) ? q.sameCnt + 3'h1 : 3'h1;
          n.lastBit = bitIn;
          if (q.decState != D_CRC) begin
            n.crc = crcStep(q.crc, bitIn);
          end
        end
        n.fieldCnt = q.fieldCnt - 7'h01;
        case (q.decState)
          D_IDLE: if (!bitIn) begin
            n.decState = D_ID;
            n.fieldCnt = 7'h0a;
            n.sameCnt  = 3'h1;
            n.lastBit  = 1'b0;
            n.crc      = '0;
            n.rxId     = '0;
          end
          D_ID: begin
            n.rxId = {q.rxId[27:0], bitIn};
            if (q.fieldCnt == 7'h00) begin
              n.decState = D_SRR;
            end
          end
          D_SRR: begin
            n.rxRtr    = bitIn;
            n.decState = D_IDE;
          end
          D_IDE: begin
            n.rxIde    = bitIn;
            n.decState = bitIn ? D_IDX : D_FDF;
            n.fieldCnt = 7'h11;
          end
          D_IDX: begin
            n.rxId = {q.rxId[27:0], bitIn};
            if (q.fieldCnt == 7'h00) begin
              n.decState = D_RTR;
            end
          end
          D_RTR: begin
            n.rxRtr    = bitIn;
            n.decState = D_FDF;
          end
          D_FDF: begin
            n.fieldCnt = 7'h03;
            if (bitIn && q.fdTolEn) begin
              // FD frame tolerated: skip it without touching the counter
              n.decState = D_WAIT;
              n.gapCnt   = '0;
            end else begin
              n.decState = q.rxIde ? D_R0 : D_DLC;
            end
          end
          D_R0: begin
            n.decState = D_DLC;
            n.fieldCnt = 7'h03;
          end
          D_DLC: begin
            dlcNew  = {q.rxDlc[2:0], bitIn};
            n.rxDlc = dlcNew;
            if (q.fieldCnt == 7'h00) begin
              n.rxData = '0;
              if (q.rxRtr || dlcNew == 4'h0) begin
                n.decState = D_CRC;
                n.fieldCnt = 7'h0e;
              end else begin
                n.decState = D_DATA;
                n.fieldCnt = 7'({(dlcNew > 4'h8) ? 4'h8 : dlcNew, 3'h0}) - 7'h01;
              end
            end
          end
          D_DATA: begin
            n.rxData = {q.rxData[62:0], bitIn};
            if (q.fieldCnt == 7'h00) begin
              n.decState = D_CRC;
              n.fieldCnt = 7'h0e;
            end
          end
          D_CRC: begin
            n.rxCrc = {q.rxCrc[13:0], bitIn};
            if (q.fieldCnt == 7'h00) begin
              if ({q.rxCrc[13:0], bitIn} != q.crc) begin
                errEv = 1'b1;
              end else begin
                n.decState = D_DEL;
              end
            end
          end
          D_DEL: begin
            if (!bitIn) begin
              errEv = 1'b1;
            end else begin
              okEv = 1'b1;
            end
          end
          D_WAIT: begin
            // ack slot and end of frame fall in here, so their errors pass
            if (!bitIn) begin
              n.gapCnt = '0;
            end else if (q.gapCnt == RECESSIVE_GAP - 4'h1) begin
              n.decState = D_IDLE;
            end else begin
              n.gapCnt = q.gapCnt + 4'h1;
            end
          end
          default: n.decState = D_WAIT;
        endcase
      end
      if (errEv || okEv) begin
        n.decState = D_WAIT;
        n.gapCnt   = '0;
      end
    end

    // ========================================================================
    // wake frame match
    aligned = q.rxData << (7'h40 - 7'({nb, 3'h0}));
    idCmp   = q.ideExt ? q.idMask : (q.idMask & BASE_ID_MASK);
    if (okEv && !q.rxRtr && q.ignoreLeft != 3'h0) begin
      n.ignoreLeft = q.ignoreLeft - 3'h1;
    end else begin
      frameOk = okEv & ~q.rxRtr
              & (((q.rxId ^ q.cfgId) & idCmp) == 29'h0)
              & (q.rxIde == q.ideExt)
              & (q.rxDlc == q.cfgDlc)
              & ((q.rxDlc == 4'h0) | (|(aligned & q.dataMask)));
    end
    if (biasOn && !q.biasPrev) begin
      n.ignoreLeft = 3'(IGNORE_FRAMES);
    end

    // ========================================================================
    // wake pattern and bus silence
    silExp = q.silCnt == SIL_LAST;
    if (!q.rx2) begin
      n.silCnt = '0;
      n.domCnt = (q.domCnt == PAT_LAST) ? q.domCnt : q.domCnt + 16'h0001;
    end else begin
      n.silCnt = silExp ? q.silCnt : q.silCnt + SIL_W'(1);
      n.domCnt = '0;
    end
    case (q.wupPhase)
      2'h0: if (!q.rx2 && q.domCnt == PAT_LAST) begin
        n.wupPhase = 2'h1;
      end
      2'h1: if (q.rx2) begin
        n.wupPhase = 2'h2;
      end
      2'h2: if (!q.rx2 && q.domCnt == PAT_LAST) begin
        wupEv      = 1'b1;
        n.wupPhase = 2'h0;
      end
      default: n.wupPhase = 2'h0;
    endcase

    // ========================================================================
    // protocol error counter
    cntOn = (q.canMode[1] | (q.swkState == S_FRAME))
          & (q.swkState != S_WOKEN);
    if (samp && errEv && cntOn) begin
      if (q.error_count_field == ERROR_COUNT_FIELD_TOP) begin
        n.error_count_field = ERROR_COUNT_FIELD_OVF;
        ovfEv  = 1'b1;
      end else if (q.error_count_field < ERROR_COUNT_FIELD_TOP) begin
        n.error_count_field = q.error_count_field + 6'h01;
      end
    end else if (okEv && cntOn && q.error_count_field != 6'h00) begin
      n.error_count_field = q.error_count_field - 6'h01;
    end

    // ========================================================================
    // selective wake state, independent of device power mode
    modeSwk = q.canMode[2] & (|q.canMode[1:0]);
    if (q.swkState == S_WOKEN) begin
      if (rearmEv) begin
        n.swkState  = S_OFF;
        n.patFlag   = 1'b0;
        n.frameFlag = 1'b0;
        clrCnt      = 1'b1;
      end
    end else if (!modeSwk) begin
      n.swkState = (q.canMode == MODE_WK) ? S_WK : (q.canMode[1] ? S_RX : S_OFF);
      if (q.swkState == S_WK && wupEv) begin
        n.swkState = S_WOKEN;
        n.patFlag  = 1'b1;
      end
    end else begin
      case (q.swkState)
        S_FRAME: begin
          if (ovfEv) begin
            n.swkState   = S_WOKEN;
            n.cfgValid   = 1'b0;
            n.protoFault = 1'b1;
            faultEv      = 1'b1;
          end else if (frameOk) begin
            n.swkState  = S_WOKEN;
            n.cfgValid  = 1'b0;
            n.frameFlag = 1'b1;
          end else if (silExp) begin
            n.swkState = S_PAT1;
            clrCnt     = 1'b1;
          end
        end
        S_PAT1: if (wupEv) begin
          n.swkState = S_FRAME;
          n.patFlag  = 1'b1;
          clrCnt     = 1'b1;
        end
        S_PAT2: if (wupEv) begin
          n.swkState = S_WOKEN;
          n.patFlag  = 1'b1;
        end
        default: begin
          // entering selective wake: configuration check
          if (q.cfgValid) begin
            n.swkState   = S_FRAME;
            n.protoFault = 1'b0;
            clrCnt       = 1'b1;
          end else begin
            n.swkState   = S_PAT2;
            n.protoFault = 1'b1;
            faultEv      = 1'b1;
          end
        end
      endcase
    end

    if ((q.canMode[1:0] == 2'h0) || (q.canMode == MODE_WK)) begin
      clrCnt = 1'b1;
    end
    if (q.fdTolEn && q.errCntDis) begin
      clrCnt = 1'b1;
    end
    if (clrCnt) begin
      n.error_count_field = '0;
    end

    // ========================================================================
    // outputs
    n.interrupt_out_n    = ~(faultEv & ~q.busIntMask);
    n.wakeOut = n.swkState == S_WOKEN;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= SWF_STATE_RST;
    end else if (ce) begin
      q <= n;
    end
  end

  assign wbRsp         = '{ack: q.wbAck, dat: q.wbDat};
  assign wakeOut       = q.wakeOut;
  assign interruptOutN = q.interrupt_out_n;

endmodule : swf_wake_filter

/* File: hw/swf_pkg.sv */
// Purpose: shared constants, register map and types of the selective wake filter
// Assumes: 10 MHz clock, 32-bit classic Wishbone with byte addresses
// Notes:   one packed struct carries all state of the filter
package swf_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ                     = 10000000;
  localparam int unsigned CLK_PERIOD_NS              = 100;
  localparam int unsigned PATTERN_DOMINANT_MIN_TIME_NS = 5000;
  localparam int unsigned PAT_MIN_CYC =
    (PATTERN_DOMINANT_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SILENCE_TIME_US            = 1000;
  localparam int unsigned SILENCE_CYC_DEF            = SILENCE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned IGNORE_FRAMES_DEF          = 4;
  localparam logic [7:0]  BIT_CYC_500K               = 8'(CLK_HZ / 500000);
  localparam logic [7:0]  BIT_CYC_125K               = 8'(CLK_HZ / 125000);
  localparam logic [7:0]  BIT_CYC_250K               = 8'(CLK_HZ / 250000);
  localparam logic [3:0]  RECESSIVE_GAP              = 4'h7;
  localparam logic [2:0]  STUFF_RUN                  = 3'h5;
  localparam int          SIL_W                      = 24;

  // ==========================================================================
  // register map
  localparam int          WB_AW        = 8;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_ID       = 8'h04;
  localparam logic [7:0]  REG_ID_MASK  = 8'h08;
  localparam logic [7:0]  REG_DLC      = 8'h0c;
  localparam logic [7:0]  REG_DMASK_HI = 8'h10;
  localparam logic [7:0]  REG_DMASK_LO = 8'h14;
  localparam logic [7:0]  REG_BAUD_DIV = 8'h18;
  localparam logic [7:0]  REG_STATUS   = 8'h1c;
  // control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_IDE      = 3;
  localparam int CTRL_FD_TOL   = 4;
  localparam int CTRL_ERR_DIS  = 5;
  localparam int CTRL_CFG_VAL  = 6;
  localparam int CTRL_BAUD_LSB = 7;
  localparam int CTRL_INT_MASK = 9;
  localparam int CTRL_REARM    = 16;
  // status fields
  localparam int STAT_FAULT    = 8;
  localparam int STAT_PATTERN  = 9;
  localparam int STAT_FRAME    = 10;
  localparam int STAT_POR      = 11;
  localparam int STAT_WOKEN    = 12;
  // transceiver modes, baud codes, identifier mask, counter limits and CRC polynomial
  localparam logic [2:0] MODE_WK   = 3'h1;
  localparam logic [1:0] BAUD_500K = 2'h0;
  localparam logic [1:0] BAUD_125K = 2'h1;
  localparam logic [1:0] BAUD_250K = 2'h2;
  localparam logic [28:0] BASE_ID_MASK = 29'h7ff;
  localparam logic [5:0]  ERROR_COUNT_FIELD_TOP     = 6'h1f;
  localparam logic [5:0]  ERROR_COUNT_FIELD_OVF     = 6'h20;
  localparam logic [14:0] CRC_POLY     = 15'h4599;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {S_OFF, S_WK, S_RX, S_FRAME, S_PAT1, S_PAT2, S_WOKEN} swf_swk_t;
  typedef enum logic [3:0] {D_IDLE, D_ID, D_SRR, D_IDE, D_IDX, D_RTR, D_FDF, D_R0, D_DLC,
                            D_DATA, D_CRC, D_DEL, D_WAIT} swf_dec_t;

  typedef struct packed {logic cyc; logic stb; logic we; logic [WB_AW-1:0] adr;
                         logic [3:0] sel; logic [31:0] dat;} swf_wb_req_t;
  typedef struct packed {logic ack; logic [31:0] dat;} swf_wb_rsp_t;

  typedef struct packed {
    logic rx1, rx2, rxPrev, biasPrev;
    logic [2:0] canMode; logic ideExt, fdTolEn, errCntDis, cfgValid; logic [1:0] baudSel;
    logic busIntMask; logic [28:0] cfgId, idMask; logic [3:0] cfgDlc;
    logic [63:0] dataMask; logic [7:0] baudDiv;
    logic [5:0] error_count_field; logic protoFault, patFlag, frameFlag, porFlag;
    swf_swk_t swkState; swf_dec_t decState;
    logic [7:0] bitCnt; logic [6:0] fieldCnt; logic [2:0] sameCnt; logic lastBit;
    logic [14:0] crc, rxCrc; logic [28:0] rxId; logic rxIde, rxRtr; logic [3:0] rxDlc;
    logic [63:0] rxData; logic [3:0] gapCnt; logic [2:0] ignoreLeft;
    logic [SIL_W-1:0] silCnt; logic [15:0] domCnt; logic [1:0] wupPhase;
    logic wbAck; logic [31:0] wbDat; logic interrupt_out_n, wakeOut;
  } swf_state_t;

  localparam swf_state_t SWF_STATE_RST = '{rx1: 1'b1, rx2: 1'b1, rxPrev: 1'b1, porFlag: 1'b1,
    interrupt_out_n: 1'b1, swkState: S_OFF, decState: D_WAIT, default: '0};

endpackage : swf_pkg

/* File: test/swf_wake_filter_chk.sv */
// Purpose: port checks of swf_wake_filter
// Assumes: one clock, rst synchronous
// Notes:   bound into the design
`timescale 1ns/1ps
module swf_wake_filter_chk (
  // clock
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            ce,
  // bus
  input swf_pkg::swf_wb_req_t wbReq,
  input swf_pkg::swf_wb_rsp_t wbRsp,
  // device
  input wire logic            wakeOut,
  input wire logic            interruptOutN
);
  import swf_pkg::*;
  logic rearm;
  assign rearm = wbRsp.ack && wbReq.we && wbReq.adr == REG_CTRL && wbReq.dat[CTRL_REARM];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // properties
  sequence s_taken;
    wbReq.cyc && wbReq.stb && !wbRsp.ack && ce;
  endsequence
  // wake may fall a few cycles after the rearm write lands
  sequence s_calm;
    !rearm && !$past(rearm) && !$past(rearm, 2) && !$past(rearm, 3);
  endsequence
  a_ack_taken: assert property (s_taken |=> wbRsp.ack) else $error("no ack");
  a_ack_single: assert property (wbRsp.ack && ce |=> !wbRsp.ack) else $error("long ack");
  a_dat_idle: assert property (!wbRsp.ack |-> wbRsp.dat == '0) else $error("stray data");
  a_hole_zero: assert property (wbRsp.ack && !wbReq.we && wbReq.adr > REG_STATUS
    |-> wbRsp.dat == '0) else $error("unmapped data");
  a_ce_freeze: assert property (!ce |=> $stable(wbRsp) && $stable(wakeOut))
    else $error("moved while frozen");
  a_rst_quiet: assert property (disable iff (1'b0) rst |=> !wbRsp.ack && !wakeOut
    && interruptOutN) else $error("busy in reset");
  a_int_pulse: assert property (!interruptOutN && ce |=> interruptOutN)
    else $error("long interrupt");
  a_wake_hold: assert property (wakeOut ##1 s_calm |-> wakeOut)
    else $error("wake lost");
endmodule : swf_wake_filter_chk
bind swf_wake_filter swf_wake_filter_chk i_swf_wake_filter_chk (.clk(clk), .rst(rst),
  .ce(ce), .wbReq(wbReq), .wbRsp(wbRsp), .wakeOut(wakeOut), .interruptOutN(interruptOutN));

/* File: test/swf_can_node.sv */
// Purpose: CAN bus node driving the receive level
// Assumes: bus rests recessive
// Notes:   dominant pulses and base data frames at 500 kBaud, no ack
`timescale 1ns/1ps
module swf_can_node (
  // clock
  input  wire logic clk,
  // bus
  output logic      rxPin
);
  // ==========================================================================
  // pulses, counts in clock cycles
  initial rxPin = 1'b1;
  task automatic pulse(input int dom, input int rec);
    repeat (dom) @(posedge clk) rxPin <= 1'b0;
    repeat (rec) @(posedge clk) rxPin <= 1'b1;
  endtask : pulse
  task automatic send(input logic b);
    repeat (swf_pkg::BIT_CYC_500K) @(posedge clk) rxPin <= b;
  endtask : send
  // idle first so a decoder left in a broken frame settles
  task automatic frame(input logic [10:0] id, input logic [7:0] d0);
    logic [26:0] hd;
    logic [14:0] crc;
    logic [41:0] all;
    logic        last;
    int          run;
    hd   = {1'b0, id, 3'b000, 4'h1, d0};
    crc  = '0;
    last = 1'b1;
    run  = 0;
    repeat (14) send(1'b1);
    for (int i = 26; i >= 0; i--) begin
      crc = {crc[13:0], 1'b0} ^ ((hd[i] ^ crc[14]) ? swf_pkg::CRC_POLY : 15'h0);
    end
    all = {hd, crc};
    for (int i = 41; i >= 0; i--) begin
      send(all[i]);
      run  = (all[i] == last) ? run + 1 : 1;
      last = all[i];
      if (run == 5) begin
        send(~last);
        last = ~last;
        run  = 1;
      end
    end
    repeat (10) send(1'b1);
  endtask : frame
endmodule : swf_can_node

/* File: test/swf_wake_filter_bench.sv */
// Purpose: self-checking bench of swf_wake_filter
// Assumes: 10 MHz clock, classic Wishbone master
// Notes:   reset values, wake pattern, fault interrupt
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module swf_wake_filter_bench;
  import swf_pkg::*;
  logic        clk, rst, ce, biasOn, lowPower, rxPin, wakeOut, interruptOutN;
  swf_wb_req_t wbReq;
  swf_wb_rsp_t wbRsp;
  logic [31:0] rd;
  int          error_cnt, n_tests, intCnt;
  swf_wake_filter #(.SILENCE_CYC(2000), .IGNORE_FRAMES(0)) i_swf_wake_filter (.clk(clk),
    .rst(rst), .ce(ce), .wbReq(wbReq), .wbRsp(wbRsp), .rxPin(rxPin), .biasOn(biasOn),
    .lowPower(lowPower), .wakeOut(wakeOut), .interruptOutN(interruptOutN));
  swf_can_node i_swf_can_node (.clk(clk), .rxPin(rxPin));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (interruptOutN === 1'b0) intCnt++;
  // ==========================================================================
  // bus and scenarios
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do @(posedge clk); while (wbRsp.ack !== 1'b1);
    rd = wbRsp.dat;
    wbReq <= '0;
  endtask : wb
  task automatic t_reset();
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK("status", 32'h0000_0800, rd)
    wb(1'b0, REG_CTRL, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    wb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    wb(1'b1, REG_STATUS, 32'h800);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK("por cleared", 32'h0, rd)
  endtask : t_reset
  task automatic t_pattern();
    wb(1'b1, REG_CTRL, 32'(MODE_WK));
    lowPower <= 1'b1;
    i_swf_can_node.pulse(PAT_MIN_CYC - 1, 20);
    i_swf_can_node.pulse(PAT_MIN_CYC - 1, 20);
    `CHK("short pattern", 1'b0, wakeOut)
    i_swf_can_node.pulse(PAT_MIN_CYC, 20);
    i_swf_can_node.pulse(PAT_MIN_CYC, 6);
    `CHK("woken", 1'b1, wakeOut)
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK("pattern flags", 5'b10010, rd[12:8])
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    lowPower <= 1'b0;
    wb(1'b1, REG_CTRL, 32'h0001_0001);
    repeat (5) @(posedge clk);
    `CHK("rearmed", 1'b0, wakeOut)
  endtask : t_pattern
  task automatic t_fault();
    int c0;
    c0 = intCnt;
    wb(1'b1, REG_CTRL, 32'h5);
    repeat (4) @(posedge clk);
    `CHK("fault irq", c0 + 1, intCnt)
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK("fault flag", 1'b1, rd[STAT_FAULT])
    wb(1'b1, REG_STATUS, 32'h100);
    wb(1'b1, REG_CTRL, 32'h200);
    wb(1'b1, REG_CTRL, 32'h205);
    repeat (4) @(posedge clk);
    `CHK("masked irq", c0 + 1, intCnt)
  endtask : t_fault
  task automatic t_frame();
    wb(1'b1, REG_ID, 32'h123);
    wb(1'b1, REG_ID_MASK, 32'h7ff);
    wb(1'b1, REG_DLC, 32'h1);
    wb(1'b1, REG_DMASK_HI, 32'h0100_0000);
    wb(1'b1, REG_CTRL, 32'h40);
    wb(1'b1, REG_CTRL, 32'h45);
    i_swf_can_node.frame(11'h124, 8'h01);
    `CHK("id mismatch", 1'b0, wakeOut)
    i_swf_can_node.frame(11'h123, 8'h02);
    `CHK("data mismatch", 1'b0, wakeOut)
    i_swf_can_node.frame(11'h123, 8'h01);
    `CHK("frame woken", 1'b1, wakeOut)
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK("frame flags", 5'b10100, rd[12:8])
  endtask : t_frame
  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    biasOn = 1'b0;
    lowPower = 1'b0;
    wbReq = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    biasOn <= 1'b1;
    t_reset();
    t_pattern();
    t_fault();
    t_frame();
    final_report();
  end
  // run needs about 5000 cycles
  initial begin
    #2000000;
    error_cnt++;
    final_report();
  end
endmodule : swf_wake_filter_bench
